/* pss_defines.svh */
// summary status word: offsets, bit positions, reset values
// assumes a management-register read port with 5-bit addresses
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_ADDR_SUMMARY   5'h10
`define PSS_ADDR_BASIC     5'h01
`define PSS_ADDR_EXPANSION 5'h06
`define PSS_ADDR_INT_EVENT 5'h12
`define PSS_ADDR_FC_COUNT  5'h14
`define PSS_ADDR_RXE_COUNT 5'h15
`define PSS_ADDR_TENBASE   5'h1A
`define PSS_BIT_RSVD       15
`define PSS_BIT_XOVER      14
`define PSS_BIT_RXERR      13
`define PSS_BIT_POLAR      12
`define PSS_BIT_FCARR      11
`define PSS_BIT_SIGDET     10
`define PSS_BIT_DLOCK      9
`define PSS_BIT_PAGE       8
`define PSS_BIT_INT        7
`define PSS_BIT_RFAULT     6
`define PSS_BIT_LINK       0
`define PSS_RESET_WORD     16'h0000
`endif

/* pss_pkg.sv */
// types for the summary status block
package pss_pkg;
    typedef logic [15:0] pss_word_t; // one management word
    typedef logic [4:0]  pss_addr_t; // management register address
endpackage : pss_pkg

/* pss_latch.sv */
// one status flag: latch high or latch low, cleared by a source read
// assumes event and clear are synchronous one-cycle or level inputs
`timescale 1ns/1ps
module pss_latch #(
    parameter bit LATCH_LOW = 1'b0 // 1: hold lows, 0: hold highs
) (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_level,  // live source level
    input  wire logic i_clear,  // read of the owning register
    output logic      o_flag
);
    logic flag_r;   // held value
    logic flag_nxt; // next held value

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flag_nxt = flag_r;
        if (LATCH_LOW) begin
            // a clearing read re-arms to the live level
            if (i_clear) flag_nxt = i_level;
            if (!i_level) flag_nxt = 1'b0;
        end else begin
            if (i_clear) flag_nxt = 1'b0;
            if (i_level) flag_nxt = 1'b1;
        end
    end

    // reset to zero, the word's default for every flag
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) flag_r <= 1'b0;
        else flag_r <= flag_nxt;
    end

    assign o_flag = flag_r;
endmodule : pss_latch

/* pss_summary.sv */
// summary status word, read over the management register port
// assumes read strobe and address arrive synchronous to i_mclk
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_summary (
    input  wire logic              i_mclk,
    input  wire logic              i_reset_n,
    input  wire logic              i_rd,        // register read strobe
    input  wire pss_pkg::pss_addr_t i_addr,     // register address
    input  wire logic              i_wr,        // write strobe, ignored here
    input  wire logic              i_xover_en,  // auto_crossover_enable
    input  wire logic              i_xover_force, // force_crossover
    input  wire logic              i_xover_algo,  // algorithm swapped state
    input  wire logic              i_rx_err,    // receive error event
    input  wire logic              i_pol_inv,   // inverted polarity seen
    input  wire logic              i_false_carr, // false carrier event
    input  wire logic              i_sig_det,   // pmd signal detect
    input  wire logic              i_desc_lock, // descrambler lock
    input  wire logic              i_page_rx,   // new page arrived pulse
    input  wire logic              i_int_evt,   // internal interrupt event
    input  wire logic              i_rem_fault, // partner remote fault
    input  wire logic              i_link_up,   // link status level
    output pss_pkg::pss_word_t     o_rdata,     // read data, registered
    output logic                   o_rvalid     // read data valid pulse
);
    // which source register is being read this cycle
    function automatic logic is_rd(input pss_pkg::pss_addr_t a,
                                   input pss_pkg::pss_addr_t want,
                                   input logic rd);
        is_rd = rd && (a == want);
    endfunction : is_rd

    logic clr_rxe, clr_ten, clr_fc, clr_exp, clr_int, clr_bas;
    assign clr_rxe = is_rd(i_addr, `PSS_ADDR_RXE_COUNT, i_rd);
    assign clr_ten = is_rd(i_addr, `PSS_ADDR_TENBASE, i_rd);
    assign clr_fc  = is_rd(i_addr, `PSS_ADDR_FC_COUNT, i_rd);
    assign clr_exp = is_rd(i_addr, `PSS_ADDR_EXPANSION, i_rd);
    assign clr_int = is_rd(i_addr, `PSS_ADDR_INT_EVENT, i_rd);
    // basic status read also re-arms the latch-low bits
    assign clr_bas = is_rd(i_addr, `PSS_ADDR_BASIC, i_rd);

    // flag sources and their clears, one latch each
    localparam int NF = 8;
    logic [NF-1:0] lvl, clr, flg;
    localparam logic [NF-1:0] LOWMASK = 8'h18; // sigdet, lock
    assign lvl = {i_rem_fault, i_int_evt, i_page_rx, i_desc_lock,
                  i_sig_det, i_false_carr, i_pol_inv, i_rx_err};
    // a summary read is in no clear term: no side effects
    assign clr = {clr_bas, clr_int, clr_exp, clr_bas,
                  clr_bas, clr_fc, clr_ten, clr_rxe};

    genvar g;
    generate
        for (g = 0; g < NF; g++) begin : g_flag
            pss_latch #(.LATCH_LOW(LOWMASK[g])) u_flag (
                .i_mclk    (i_mclk),
                .i_reset_n (i_reset_n),
                .i_level   (lvl[g]),
                .i_clear   (clr[g]),
                .o_flag    (flg[g])
            );
        end
    endgenerate

    // crossover state: forced wins, else algorithm when enabled
    logic xover_r, xover_nxt;
    always_comb begin
        if (i_xover_force) xover_nxt = 1'b1;
        else if (i_xover_en) xover_nxt = i_xover_algo;
        else xover_nxt = 1'b0;
    end

    // assembled word and read answer
    pss_pkg::pss_word_t word, rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    always_comb begin
        word = `PSS_RESET_WORD;
        word[`PSS_BIT_RSVD]   = 1'b0;
        word[`PSS_BIT_XOVER]  = xover_r;
        word[`PSS_BIT_RXERR]  = flg[0];
        word[`PSS_BIT_POLAR]  = flg[1];
        word[`PSS_BIT_FCARR]  = flg[2];
        word[`PSS_BIT_SIGDET] = flg[3];
        word[`PSS_BIT_DLOCK]  = flg[4];
        word[`PSS_BIT_PAGE]   = flg[5];
        word[`PSS_BIT_INT]    = flg[6];
        word[`PSS_BIT_RFAULT] = flg[7];
        word[`PSS_BIT_LINK]   = i_link_up;
        rvalid_nxt = is_rd(i_addr, `PSS_ADDR_SUMMARY, i_rd);
        // writes never touch the word; idle data holds zero
        rdata_nxt = rvalid_nxt ? word : `PSS_RESET_WORD;
    end

    // registers only; all reset to zero
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xover_r  <= 1'b0;
            rdata_r  <= `PSS_RESET_WORD;
            rvalid_r <= 1'b0;
        end else begin
            xover_r  <= xover_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign o_rdata  = rdata_r;
    assign o_rvalid = rvalid_r;

    // reserved bit never rises, whatever the bus does
    a_rsvd_zero: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) o_rdata[15] == 1'b0)
        else $error("bit 15 not zero");
    // a write strobe alone never raises an answer
    a_write_ignored: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (i_wr && !i_rd) |=> !o_rvalid)
        else $error("write produced an answer");
    // no enable and no force: pairs read as normal
    a_xover_off: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        (!i_xover_en && !i_xover_force) |=> !xover_r)
        else $error("crossover shown while disabled");
    // the answer carries the registered crossover state
    a_xover_word: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        rvalid_nxt |=> o_rdata[14] == $past(xover_r))
        else $error("crossover bit wrong in answer");
    // force wins over the algorithm and the enable
    a_xover_force: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_xover_force |=> xover_r)
        else $error("forced crossover not shown");
    // enabled, not forced: one cycle behind the algorithm
    a_xover_track: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (i_xover_en && !i_xover_force)
        |=> xover_r == $past(i_xover_algo))
        else $error("crossover not tracking");
    // receive error event sets the latch next cycle
    a_rxerr_hold: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_rx_err |=> flg[0])
        else $error("rx error not latched");
    // counter read with no new event drops the latch
    a_rxerr_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_rxe && !i_rx_err) |=> !flg[0])
        else $error("rx error not cleared");
    // without the counter read the latch stays up
    a_rxerr_keep: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (flg[0] && !clr_rxe) |=> flg[0])
        else $error("rx error dropped");
    // inverted polarity sets bit 12
    a_pol_set: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_pol_inv |=> flg[1])
        else $error("polarity not latched");
    // tenbase status read clears it once polarity is good
    a_pol_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_ten && !i_pol_inv) |=> !flg[1])
        else $error("polarity not cleared");
    // other reads, the summary one too, leave it alone
    a_pol_keep: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (flg[1] && !clr_ten) |=> flg[1])
        else $error("polarity dropped");
    // false carrier event sets bit 11
    a_fc_set: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_false_carr |=> flg[2])
        else $error("false carrier not latched");
    // held until its counter is read
    a_fc_hold: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (flg[2] && !clr_fc) |=> flg[2])
        else $error("false carrier dropped");
    // counter read with no new event drops the latch
    a_fc_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_fc && !i_false_carr) |=> !flg[2])
        else $error("false carrier not cleared");
    // a loss of signal stays low until re-armed
    a_sig_low: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (!i_sig_det && !flg[3]
        ##1 !clr_bas) |=> !flg[3])
        else $error("signal loss not held");
    // re-arm read with signal present shows it again
    a_sig_rearm: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_bas && i_sig_det) |=> flg[3])
        else $error("signal detect not re-armed");
    // a loss of lock drops bit 9 next cycle
    a_lock_low: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) !i_desc_lock |=> !flg[4])
        else $error("lock loss missed");
    // re-arm read with lock present shows it again
    a_lock_rearm: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_bas && i_desc_lock) |=> flg[4])
        else $error("lock not re-armed");
    // a new page sets bit 8
    a_page_set: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_page_rx |=> flg[5])
        else $error("page not latched");
    // only the expansion read clears it
    a_page_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_exp && !i_page_rx) |=> !flg[5])
        else $error("page not cleared");
    // an interrupt event makes bit 7 pending
    a_int_set: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_int_evt |=> flg[6])
        else $error("interrupt not pending");
    // event register read clears the pending state
    a_int_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_int && !i_int_evt) |=> !flg[6])
        else $error("interrupt not cleared");
    // partner remote fault sets bit 6
    a_fault_set: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) i_rem_fault |=> flg[7])
        else $error("remote fault not latched");
    // basic status read clears it
    a_fault_clear: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (clr_bas && !i_rem_fault) |=> !flg[7])
        else $error("remote fault not cleared");
    // a summary read is answered on the next cycle
    a_valid_pulse: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) rvalid_nxt |=> o_rvalid)
        else $error("summary read not answered");
    // other addresses give no answer and idle data stays zero
    a_idle_zero: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        !rvalid_nxt |=> (!o_rvalid && o_rdata == 16'h0000))
        else $error("answer without summary read");
    // bits left out of this block always read zero
    a_low_bits: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) o_rdata[5:1] == 5'h00)
        else $error("unused low bits not zero");
    // a summary read must not clear a pending interrupt
    a_no_side: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n) (rvalid_nxt && flg[6]) |=> flg[6])
        else $error("summary read cleared flag");
    // link bit is the live level at the read edge
    a_read_data: assert property (@(posedge i_mclk)
        disable iff (!i_reset_n)
        rvalid_nxt |=> o_rdata[0] == $past(i_link_up))
        else $error("link bit wrong");
endmodule : pss_summary

/* pss_mgmt_model.sv */
// management controller model: turns a bench request into one read
// assumes requests change on rising edges of the management clock
`timescale 1ns/1ps
module pss_mgmt_model (
    input  wire logic          i_mclk,
    input  wire logic          i_req,  // issue one read next cycle
    input  wire logic [2:0]    i_sel,  // which register to read
    output logic               o_rd,   // one-cycle read strobe
    output pss_pkg::pss_addr_t o_addr  // register address
);
    initial o_rd = 1'b0; // quiet before the first edge
    // one strobe per request; the last entry is an unmapped place
    always @(posedge i_mclk) begin
        o_rd <= i_req;
        case (i_sel)
            3'h0: o_addr <= 5'h10; // summary word
            3'h1: o_addr <= 5'h01; // basic status
            3'h2: o_addr <= 5'h06; // expansion
            3'h3: o_addr <= 5'h12; // cause of a pending interrupt
            3'h4: o_addr <= 5'h14; // false carrier counter
            3'h5: o_addr <= 5'h15; // receive error counter
            3'h6: o_addr <= 5'h1A; // tenbase status
            default: o_addr <= 5'h03; // unmapped, must not answer
        endcase
    end
endmodule : pss_mgmt_model

/* phy_status_summary_register_tb.sv */
// random bench for the summary word against a bit-level model
// assumes the management model above supplies every read strobe
`timescale 1ns/1ps
module phy_status_summary_register_tb;
    logic               i_mclk = 1'b0;      // 100 MHz clock
    logic               i_reset_n = 1'b0;   // async reset
    logic [12:0]        in_v = 13'h0000;    // status inputs and write
    logic               req = 1'b0;         // read request
    logic [2:0]         sel = 3'h0;         // register choice
    logic               rd;                 // strobe from the model
    pss_pkg::pss_addr_t addr;               // address from the model
    pss_pkg::pss_word_t o_rdata;            // design read data
    logic               o_rvalid;           // design read valid
    bit [15:0]          st, ew;             // model flags, expected word
    bit                 ev;                 // expected valid
    bit [31:0]          r = 32'h0000BA53;   // random state
    int                 err_total, total_checks, cyc;
    logic [4:0]         c;                  // address read this edge
    always #5 i_mclk = ~i_mclk;
    pss_mgmt_model i_mgmt (.i_mclk(i_mclk), .i_req(req), .i_sel(sel),
        .o_rd(rd), .o_addr(addr));
    pss_summary i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_rd(rd), .i_addr(addr), .i_wr(in_v[12]),
        .i_xover_en(in_v[0]), .i_xover_force(in_v[1]),
        .i_xover_algo(in_v[2]), .i_rx_err(in_v[3]), .i_pol_inv(in_v[4]),
        .i_false_carr(in_v[5]), .i_sig_det(in_v[6]),
        .i_desc_lock(in_v[7]), .i_page_rx(in_v[8]), .i_int_evt(in_v[9]),
        .i_rem_fault(in_v[10]), .i_link_up(in_v[11]),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid));
    function automatic bit [31:0] lfsr(input bit [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h00000000);
    endfunction : lfsr
    task automatic chk_bit(input logic got, input bit exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input pss_pkg::pss_word_t got,
                            input bit [15:0]          exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // hang guard in its own process so nothing follows the finish
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin // tests need about 2010 cycles
            err_total++;
            complete_run();
        end
    end
    // model first on old inputs, then new random inputs by nba
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st = 16'h0000;
            ev = 1'b0;
            ew = 16'h0000;
        end else begin
            c = rd ? addr : 5'h1F;
            ev = (c == 5'h10); // only the summary address answers
            ew = ev ? {1'b0, st[14:6], 5'h00, in_v[11]} : 16'h0000;
            st[14] = in_v[1] | (in_v[0] & in_v[2]);
            st[13] = in_v[3] | (st[13] & c != 5'h15);
            st[12] = in_v[4] | (st[12] & c != 5'h1A);
            st[11] = in_v[5] | (st[11] & c != 5'h14);
            st[10] = in_v[6] & (st[10] | c == 5'h01);
            st[9] = in_v[7] & (st[9] | c == 5'h01);
            st[8] = in_v[8] | (st[8] & c != 5'h06);
            st[7] = in_v[9] | (st[7] & c != 5'h12);
            st[6] = in_v[10] | (st[6] & c != 5'h01);
        end
        r = lfsr(r);
        // events rare so clears show; levels toggle freely
        in_v <= (r[12:0] & r[25:13] & r[31:19] & 13'h0738)
              | (r[12:0] & 13'h18C7);
        req <= r[27];
        sel <= r[30:28];
    end
    // outputs compared where settled, every cycle
    always @(negedge i_mclk) begin
        chk_bit(o_rvalid, ev);
        chk_word(o_rdata, ew);
        chk_word(o_rdata & 16'h4000, ew & 16'h4000);
        chk_word(o_rdata & 16'h3800, ew & 16'h3800);
        chk_word(o_rdata & 16'h07C0, ew & 16'h07C0);
    end
    initial begin
        repeat (4) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (1000) @(negedge i_mclk);
        $display("test random after first reset done");
        #1 i_reset_n = 1'b0; // mid-run reset clears all flags
        repeat (4) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (1000) @(negedge i_mclk);
        $display("test random after second reset done");
        complete_run();
    end
endmodule : phy_status_summary_register_tb
